// ==== src/dlos_status.sv ====
// Loop operating status register bank with interrupt logic
//
// Contract
// RQ1: Status register at 0x09 is read-only; writes there change nothing.
// RQ2: Each loop follows its offset up to the hard limit, then clamps.
// RQ3: Each loop flags alarm while its offset exceeds the soft limit.
// RQ4: Bit 5 shows the main loop soft frequency alarm.
// RQ5: Bit 4 shows the auxiliary loop soft frequency alarm.
// RQ6: Bits 2:0 show main loop mode; 000 and 011 unused.
// RQ7: Bit 6 shows whether the auxiliary loop is phase locked.
// RQ8: Bits 7 and 3 read zero; fields are live, not latched.
//
// Own map beside the status word: 0x20 event status, 0x21 event enable,
// 0x22 event clear (write ones), 0x23 limit select in bits 7:6, then
// 0x24 and 0x25 for the low and high byte of the selected limit.
// Limits reset fully open, so no clamp or alarm acts until programmed.
`timescale 1ns/1ps
module dlos_status
    import dlos_pkg::*;
#(
    parameter int OFS_W = 16
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Loop sources
    input wire logic [2:0] main_loop_mode_code_in,
    input wire logic aux_loop_locked_in,
    input wire logic [OFS_W-1:0] main_offset_in,
    input wire logic [OFS_W-1:0] aux_offset_in,
    // Clamped loop offsets
    output logic [OFS_W-1:0] main_clamped_out,
    output logic [OFS_W-1:0] aux_clamped_out,
    // Interrupt
    output logic irq_out
);
    import dlos_pkg::*;

    typedef struct packed {
        // Synchroniser stages and the filtered, reported values
        logic [2:0] mode_s1;
        logic [2:0] mode_s2;
        logic [2:0] mode_s3;
        logic [2:0] mode;
        logic lock_s1;
        logic lock;
        // Event state and interrupt registers
        logic [2:0] mode_prev;
        logic lock_prev;
        logic [DLOS_EV_W-1:0] int_status;
        logic [DLOS_EV_W-1:0] int_enable;
        // Programmed limits and the byte selector
        logic [OFS_W-1:0] main_hard;
        logic [OFS_W-1:0] main_soft;
        logic [OFS_W-1:0] aux_hard;
        logic [OFS_W-1:0] aux_soft;
        logic [1:0] lim_sel;
        // Read data and alarm copies for change detection
        logic [7:0] rdata;
        logic main_alarm_q;
        logic aux_alarm_q;
    } dlos_state_t;

    dlos_state_t state;
    dlos_state_t next_state;
    logic main_alarm;
    logic aux_alarm;
    logic [7:0] status_word;
    logic [DLOS_EV_W-1:0] events;

    // Limit registers are written a byte at a time through a selector
    function automatic logic [OFS_W-1:0] dlos_set_byte(input logic [OFS_W-1:0] cur,
                                                      input logic hi,
                                                      input logic [7:0] b);
        logic [OFS_W-1:0] r;
        r = cur;
        if (hi) begin
            r[OFS_W-1:8] = b[OFS_W-9:0];
        end else begin
            r[7:0] = b;
        end
        return r;
    endfunction : dlos_set_byte

    // Write strobe aimed at one address
    function automatic logic dlos_wr_hit(input logic wr,
                                         input logic [7:0] addr,
                                         input logic [7:0] target);
        return wr && (addr == target);
    endfunction : dlos_wr_hit

    // Both loops share one comparator design
    // Its flops put clamp and alarm one cycle behind the offset
    dlos_limit #(.W(OFS_W)) u_main_lim (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .offset_in(main_offset_in),
        .hard_limit_in(state.main_hard),
        .soft_limit_in(state.main_soft),
        .clamped_out(main_clamped_out),
        .alarm_out(main_alarm)
    );

    dlos_limit #(.W(OFS_W)) u_aux_lim (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .offset_in(aux_offset_in),
        .hard_limit_in(state.aux_hard),
        .soft_limit_in(state.aux_soft),
        .clamped_out(aux_clamped_out),
        .alarm_out(aux_alarm)
    );

    // Live status word, unused bits forced low
    // Built from flops at each read, so nothing here holds a past state
    always_comb begin
        status_word = 8'h00; // [RQ8]
        status_word[DLOS_BIT_AUX_LOCK] = state.lock; // [RQ7]
        status_word[DLOS_BIT_MAIN_ALARM] = main_alarm; // [RQ4]
        status_word[DLOS_BIT_AUX_ALARM] = aux_alarm; // [RQ5]
        status_word[DLOS_MODE_MSB:0] = state.mode; // [RQ6]
    end

    // Change events feeding the sticky status; each compares a flop with its
    // one-cycle-old copy, so no path runs back through the next-state logic
    always_comb begin
        events = '0;
        events[DLOS_EV_MODE] = (state.mode != state.mode_prev);
        events[DLOS_EV_MAIN_ALARM] = (main_alarm != state.main_alarm_q);
        events[DLOS_EV_AUX_ALARM] = (aux_alarm != state.aux_alarm_q);
        events[DLOS_EV_AUX_LOCK] = (state.lock != state.lock_prev);
    end

    // Register decode and next state
    always_comb begin
        next_state = state;
        // Mode and lock come from another clock region, so two stages each
        next_state.mode_s1 = main_loop_mode_code_in;
        next_state.mode_s2 = state.mode_s1;
        next_state.lock_s1 = aux_loop_locked_in;
        next_state.lock = state.lock_s1;
        // A code in flight may land bit by bit; report it only after two
        // equal samples, at the price of two more cycles of latency than the lock bit
        next_state.mode_s3 = state.mode_s2;
        if (state.mode_s2 == state.mode_s3) begin
            next_state.mode = state.mode_s2; // [RQ6]
        end
        // One-cycle-old copies for the change events
        next_state.mode_prev = state.mode;
        next_state.lock_prev = state.lock;
        next_state.main_alarm_q = main_alarm;
        next_state.aux_alarm_q = aux_alarm;
        // Read data stand one cycle only
        next_state.rdata = 8'h00;
        // Clear first so a same-cycle event wins
        if (dlos_wr_hit(reg_wr_in, reg_addr_in, DLOS_ADDR_INT_CLEAR)) begin
            next_state.int_status = state.int_status & ~reg_wdata_in[DLOS_EV_W-1:0];
        end
        next_state.int_status = next_state.int_status | events;
        // Status address decodes no write at all
        if (reg_wr_in) begin // [RQ1]
            case (reg_addr_in)
                DLOS_ADDR_INT_ENABLE: next_state.int_enable = reg_wdata_in[DLOS_EV_W-1:0];
                DLOS_ADDR_LIMITS: begin
                    // Bits 7:6 pick the limit that the byte writes reach
                    next_state.lim_sel = reg_wdata_in[7:6];
                end
                // Each byte acts at once, so a limit passes a mixed value
                DLOS_ADDR_LIMIT_LO: begin
                    case (state.lim_sel)
                        2'h0: next_state.main_hard = dlos_set_byte(state.main_hard, 1'b0, reg_wdata_in);
                        2'h1: next_state.main_soft = dlos_set_byte(state.main_soft, 1'b0, reg_wdata_in);
                        2'h2: next_state.aux_hard = dlos_set_byte(state.aux_hard, 1'b0, reg_wdata_in);
                        default: next_state.aux_soft = dlos_set_byte(state.aux_soft, 1'b0, reg_wdata_in);
                    endcase
                end
                // High byte of the selected limit
                DLOS_ADDR_LIMIT_HI: begin
                    case (state.lim_sel)
                        2'h0: next_state.main_hard = dlos_set_byte(state.main_hard, 1'b1, reg_wdata_in);
                        2'h1: next_state.main_soft = dlos_set_byte(state.main_soft, 1'b1, reg_wdata_in);
                        2'h2: next_state.aux_hard = dlos_set_byte(state.aux_hard, 1'b1, reg_wdata_in);
                        default: next_state.aux_soft = dlos_set_byte(state.aux_soft, 1'b1, reg_wdata_in);
                    endcase
                end
                default: ;
            endcase
        end
        // Reads have no side effects; sticky bits go only by the clear register
        if (reg_rd_in) begin
            case (reg_addr_in)
                DLOS_ADDR_STATUS: next_state.rdata = status_word;
                DLOS_ADDR_INT_STATUS: next_state.rdata = {4'h0, state.int_status};
                DLOS_ADDR_INT_ENABLE: next_state.rdata = {4'h0, state.int_enable};
                DLOS_ADDR_LIMITS: next_state.rdata = {state.lim_sel, 6'h00};
                default: next_state.rdata = 8'h00;
            endcase
        end
    end

    // Single state register
    // Reset branch holds constants only: limits open, enables off
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= '0;
            state.int_enable <= DLOS_RST_INT_ENABLE;
            state.main_hard <= DLOS_RST_HARD_LIMIT;
            state.main_soft <= DLOS_RST_SOFT_LIMIT;
            state.aux_hard <= DLOS_RST_HARD_LIMIT;
            state.aux_soft <= DLOS_RST_SOFT_LIMIT;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata_out = state.rdata;
    // Interrupt level from flops only, so the decode cannot glitch it
    assign irq_out = |(state.int_status & state.int_enable);
endmodule : dlos_status

// ==== src/dlos_pkg.sv ====
// Package with register map, field layout and mode codes of the loop status bank
package dlos_pkg;
    // Register map
    localparam logic [7:0] DLOS_ADDR_STATUS = 8'h09;
    localparam logic [7:0] DLOS_ADDR_INT_STATUS = 8'h20;
    localparam logic [7:0] DLOS_ADDR_INT_ENABLE = 8'h21;
    localparam logic [7:0] DLOS_ADDR_INT_CLEAR = 8'h22;
    localparam logic [7:0] DLOS_ADDR_LIMITS = 8'h23;
    localparam logic [7:0] DLOS_ADDR_LIMIT_LO = 8'h24;
    localparam logic [7:0] DLOS_ADDR_LIMIT_HI = 8'h25;
    // Status field positions
    localparam int DLOS_BIT_AUX_LOCK = 6;
    localparam int DLOS_BIT_MAIN_ALARM = 5;
    localparam int DLOS_BIT_AUX_ALARM = 4;
    localparam int DLOS_MODE_MSB = 2;
    // Event bit positions in interrupt registers
    localparam int DLOS_EV_MODE = 0;
    localparam int DLOS_EV_MAIN_ALARM = 1;
    localparam int DLOS_EV_AUX_ALARM = 2;
    localparam int DLOS_EV_AUX_LOCK = 3;
    localparam int DLOS_EV_W = 4;
    // Reset values
    localparam logic [3:0] DLOS_RST_INT_ENABLE = 4'h0;
    localparam logic [15:0] DLOS_RST_OFFSET = 16'h0000;
    localparam logic [15:0] DLOS_RST_HARD_LIMIT = 16'hFFFF;
    localparam logic [15:0] DLOS_RST_SOFT_LIMIT = 16'hFFFF;
    // Main loop mode codes
    typedef enum logic [2:0] {
        DLOS_MODE_FREE_RUN = 3'h1,
        DLOS_MODE_HOLDOVER = 3'h2,
        DLOS_MODE_LOCKED = 3'h4,
        DLOS_MODE_PRELOCK2 = 3'h5,
        DLOS_MODE_PRELOCK = 3'h6,
        DLOS_MODE_PHASE_LOST = 3'h7
    } dlos_mode_t;
endpackage : dlos_pkg

// ==== src/dlos_limit.sv ====
// Frequency limiter and soft alarm comparator for one loop
`timescale 1ns/1ps
module dlos_limit #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // Requested offset magnitude and limits
    input wire logic [W-1:0] offset_in,
    input wire logic [W-1:0] hard_limit_in,
    input wire logic [W-1:0] soft_limit_in,
    // Clamped offset and alarm
    output logic [W-1:0] clamped_out,
    output logic alarm_out
);
    typedef struct packed {
        logic [W-1:0] clamped;
        logic alarm;
    } dlos_lim_state_t;

    dlos_lim_state_t state;
    dlos_lim_state_t next_state;

    // Clamp at hard limit, flag beyond soft limit
    always_comb begin
        next_state = state;
        next_state.clamped = (offset_in > hard_limit_in) ? hard_limit_in : offset_in; // [RQ2]
        next_state.alarm = (offset_in > soft_limit_in); // [RQ3]
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign clamped_out = state.clamped;
    assign alarm_out = state.alarm;
endmodule : dlos_limit

// ==== sim/dlos_status_asserts.sv ====
// Assertion checker for the loop status register bank
`timescale 1ns/1ps
module dlos_status_chk
    import dlos_pkg::*;
#(
    parameter int OFS_W = 16
) (
    // Clock, reset, register port
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // Loop sources and results
    input wire logic [2:0] main_loop_mode_code_in,
    input wire logic aux_loop_locked_in,
    input wire logic [OFS_W-1:0] main_offset_in,
    input wire logic [OFS_W-1:0] aux_offset_in,
    input wire logic [OFS_W-1:0] main_clamped_out,
    input wire logic [OFS_W-1:0] aux_clamped_out,
    input wire logic irq_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    logic [2:0] age;
    wire rd_sts = reg_rd_in && reg_addr_in == DLOS_ADDR_STATUS;
    // Quiet time of mode and lock; the synchroniser hides fresh changes
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) age <= 3'h0;
        else if (!$stable({main_loop_mode_code_in, aux_loop_locked_in})) age <= 3'h0;
        else if (age != 3'h7) age <= age + 3'h1;
    end
    spare_zero_a: assert property (rd_sts |=> !reg_rdata_out[7] && !reg_rdata_out[3])
        else $error("Spare status bits set");
    mode_live_a: assert property (rd_sts && age >= 3'h4 |=>
        reg_rdata_out[2:0] == $past(main_loop_mode_code_in)) else $error("Mode field wrong");
    lock_live_a: assert property (rd_sts && age >= 3'h4 |=>
        reg_rdata_out[6] == $past(aux_loop_locked_in)) else $error("Lock bit wrong");
    main_quiet_a: assert property (rd_sts && main_offset_in == '0 &&
        $past(main_offset_in) == '0 && $past(main_offset_in, 2) == '0 |=> !reg_rdata_out[5])
        else $error("Main alarm with zero offset");
    aux_quiet_a: assert property (rd_sts && aux_offset_in == '0 &&
        $past(aux_offset_in) == '0 && $past(aux_offset_in, 2) == '0 |=> !reg_rdata_out[4])
        else $error("Aux alarm with zero offset");
    main_clamp_a: assert property (main_clamped_out <= $past(main_offset_in))
        else $error("Main clamp above offset");
    aux_clamp_a: assert property (aux_clamped_out <= $past(aux_offset_in))
        else $error("Aux clamp above offset");
    wr_quiet_a: assert property (reg_wr_in |=> reg_rdata_out == 8'h00)
        else $error("Write drove read data");
    cover property (rd_sts ##1 reg_rdata_out[5]);
    cover property ($rose(irq_out));
    cover property (reg_wr_in && reg_addr_in == DLOS_ADDR_STATUS);
endmodule : dlos_status_chk

// ==== sim/testbench.sv ====
// Self-checking bench for the loop status register bank
`timescale 1ns/1ps
module testbench;
    import dlos_pkg::*;
    logic mclk_in = 1'b0, rstn_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, irq_out;
    logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, d;
    logic aux_loop_locked_in = 1'b0;
    logic [2:0] main_loop_mode_code_in = 3'h1;
    logic [15:0] main_offset_in = 16'h0000, aux_offset_in = 16'h0000;
    logic [15:0] main_clamped_out, aux_clamped_out, o;
    int errors = 0, compares = 0;
    dlos_status #(.OFS_W(16)) DUT (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out),
        .main_loop_mode_code_in(main_loop_mode_code_in),
        .aux_loop_locked_in(aux_loop_locked_in),
        .main_offset_in(main_offset_in),
        .aux_offset_in(aux_offset_in),
        .main_clamped_out(main_clamped_out),
        .aux_clamped_out(aux_clamped_out),
        .irq_out(irq_out)
    );
    initial forever #4 mclk_in = ~mclk_in;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One-cycle strobes, launched just after an edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk_in);
        {reg_wr_in, reg_addr_in, reg_wdata_in} <= {1'b1, a, v};
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_in);
        {reg_rd_in, reg_addr_in} <= {1'b1, a};
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask : rd
    // Sources settle past the two-flop synchroniser before any read
    task automatic src(input logic [2:0] m, input logic l, input logic [15:0] mo, ao);
        @(posedge mclk_in);
        {main_loop_mode_code_in, aux_loop_locked_in} <= {m, l};
        {main_offset_in, aux_offset_in} <= {mo, ao};
        repeat (5) @(posedge mclk_in);
    endtask : src
    task automatic lim(input logic [1:0] s, input logic [15:0] v);
        wr(DLOS_ADDR_LIMITS, {s, 6'h00});
        wr(DLOS_ADDR_LIMIT_LO, v[7:0]);
        wr(DLOS_ADDR_LIMIT_HI, v[15:8]);
    endtask : lim
    task automatic t_modes;
        dlos_mode_t m;
        m = m.first();
        for (int i = 0; i < 6; i++) begin
            src(m, i[0], 16'h0000, 16'h0000);
            rd(DLOS_ADDR_STATUS);
            chk(d, {9'h000, i[0], 3'h0, m});
            m = m.next();
        end
    endtask : t_modes
    task automatic t_ro;
        src(DLOS_MODE_FREE_RUN, 1'b1, 16'h0000, 16'h0000);
        wr(DLOS_ADDR_STATUS, 8'hFF);
        rd(DLOS_ADDR_STATUS);
        chk(d, 16'h0041);
        rd(8'h7F);
        chk(d, 16'h0000);
    endtask : t_ro
    // Soft limit 0x10, hard limit 0x20 on both loops; cases straddle each
    task automatic t_limits;
        lim(2'h0, 16'h0020);
        lim(2'h1, 16'h0010);
        lim(2'h2, 16'h0020);
        lim(2'h3, 16'h0010);
        for (int i = 0; i < 4; i++) begin
            o = 16'h0010 + 16'(i[0]) + 16'(i[1] * 16);
            src(DLOS_MODE_FREE_RUN, 1'b1, o, o ^ 16'h0001);
            rd(DLOS_ADDR_STATUS);
            chk(d, {9'h000, 1'b1, o > 16'h10, (o ^ 16'h1) > 16'h10, 4'h1});
            chk(main_clamped_out, (o > 16'h20) ? 16'h0020 : o);
            chk(aux_clamped_out, ((o ^ 16'h1) > 16'h20) ? 16'h0020 : o ^ 16'h1);
        end
    endtask : t_limits
    // Main alarm falls with its event enabled, then mask and clear
    task automatic t_irq;
        wr(DLOS_ADDR_INT_CLEAR, 8'h0F);
        wr(DLOS_ADDR_INT_ENABLE, 8'h02);
        src(DLOS_MODE_FREE_RUN, 1'b1, 16'h0000, 16'h0020);
        rd(DLOS_ADDR_INT_STATUS);
        chk(d, 16'h0002);
        chk(irq_out, 16'h0001);
        wr(DLOS_ADDR_INT_ENABLE, 8'h00);
        repeat (2) @(posedge mclk_in);
        chk(irq_out, 16'h0000);
        wr(DLOS_ADDR_INT_CLEAR, 8'h02);
        rd(DLOS_ADDR_INT_STATUS);
        chk(d, 16'h0000);
    endtask : t_irq
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (16) @(posedge mclk_in);
        rstn_in <= 1'b1;
        t_modes();
        t_ro();
        t_limits();
        t_irq();
        tally_and_finish();
    end
    // Watchdog well past the roughly 150 cycles the tests need
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
endmodule : testbench
bind dlos_status dlos_status_chk #(.OFS_W(OFS_W)) u_chk (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .main_loop_mode_code_in(main_loop_mode_code_in),
    .aux_loop_locked_in(aux_loop_locked_in),
    .main_offset_in(main_offset_in),
    .aux_offset_in(aux_offset_in),
    .main_clamped_out(main_clamped_out),
    .aux_clamped_out(aux_clamped_out),
    .irq_out(irq_out)
);
